// ---- rtl/int11_aggr_consts.svh ----
// constants for the interrupt-11 aggregator: register indices, byte addresses,
// field positions and reset values.
// assumes an AHB-Lite master with 32-bit data; each register takes one aligned word.
`ifndef INT11_AGGR_CONSTS_SVH
`define INT11_AGGR_CONSTS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define IDX_REQUEST_FLAGS 32'h0000_28a2
`define IDX_INPUT_TYPE 32'h0000_28a3
`define IDX_OUTPUT_TYPE 32'h0000_28a4
`define IDX_SOURCE_ENABLES 32'h0000_28a5
`define IDX_PENDING_FLAGS 32'h0000_28a6
`define IDX_IRQ_STATUS 32'h0000_28a8
`define IDX_IRQ_MASK 32'h0000_28a9
`define IDX_PERIPH_GATE_A 32'h0000_2d00
`define IDX_PERIPH_GATE_B 32'h0000_2d01

// ==========================================================================
// byte addresses seen on haddr
`define ADDR_REQUEST_FLAGS (`IDX_REQUEST_FLAGS << 2)
`define ADDR_INPUT_TYPE (`IDX_INPUT_TYPE << 2)
`define ADDR_OUTPUT_TYPE (`IDX_OUTPUT_TYPE << 2)
`define ADDR_SOURCE_ENABLES (`IDX_SOURCE_ENABLES << 2)
`define ADDR_PENDING_FLAGS (`IDX_PENDING_FLAGS << 2)
`define ADDR_IRQ_STATUS (`IDX_IRQ_STATUS << 2)
`define ADDR_IRQ_MASK (`IDX_IRQ_MASK << 2)
`define ADDR_PERIPH_GATE_A (`IDX_PERIPH_GATE_A << 2)
`define ADDR_PERIPH_GATE_B (`IDX_PERIPH_GATE_B << 2)

// ==========================================================================
// field positions and sizes
`define NUM_SOURCES 7
`define SRC_SERIAL_ILLEGAL 4
`define SRC_SERIAL_TX 5
`define GATE_A_SERIAL_EN_BIT 6
`define GATE_B_INT11_GATE_BIT 3

// ==========================================================================
// reset values
`define RST_INPUT_TYPE 8'h7f
`define RST_OUTPUT_TYPE 8'h01
`define RST_ZERO8 8'h00
`define RST_ZERO7 7'h00

`endif

// ---- rtl/int11_aggr_pkg.sv ----
// types shared by the interrupt-11 aggregator files.
// assumes nothing beyond a SystemVerilog compiler.
package int11_aggr_pkg;

   // ==========================================================================
   // event pulses from the peripherals, one clock each, same clock domain
   typedef struct packed {
      logic comparator;
      logic serial_tx_done;
      logic serial_illegal_data;
      logic [2:0] timer_capture;
      logic timer_overflow;
   } src_events_s;

   // ==========================================================================
   // bus slave phases
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ_WAIT,
      BUS_READ_DONE
   } bus_state_e;

endpackage

// ---- rtl/src_flag_cell.sv ----
// one source of the aggregator: its request flag and its pending bit.
// assumes event and write strobes are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module src_flag_cell (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hw_event,
   input wire logic enabled,
   input wire logic flag_wr,
   input wire logic flag_wr_data,
   input wire logic pend_wr,
   input wire logic pend_wr_data,
   output logic flag,
   output logic pending,
   output logic flag_set
);

   logic hw_set;
   logic sw_set;
   logic sw_clr;
   logic pend_set;
   logic pend_clr;
   logic flag_r;
   logic pend_r;

   // set terms need the enable; clear terms do not
   assign hw_set = hw_event & enabled;
   assign sw_set = flag_wr & flag_wr_data & enabled;
   assign sw_clr = flag_wr & ~flag_wr_data;
   assign pend_set = hw_set & flag_r;
   assign pend_clr = pend_wr & ~pend_wr_data;
   assign flag_set = hw_set | sw_set;

   // request flag; a set in the clearing cycle wins so no event is lost
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_r <= 1'b0;
      end else if (flag_set) begin
         flag_r <= 1'b1;
      end else if (sw_clr) begin
         flag_r <= 1'b0;
      end
   end

   // pending bit; only a software write of zero clears it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_r <= 1'b0;
      end else if (pend_set) begin
         pend_r <= 1'b1;
      end else if (pend_clr) begin
         pend_r <= 1'b0;
      end
   end

   assign flag = flag_r;
   assign pending = pend_r;

endmodule

`default_nettype wire

// ---- rtl/int11_aggregator.sv ----
// interrupt-11 aggregator: seven peripheral events into one core request,
// with an AHB-Lite register slave and a maskable read-to-clear event status.
// assumes events come from logic on clk_sys, as one-cycle pulses, and a single
// AHB-Lite master doing single word transfers; hready is this slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none
`include "int11_aggr_consts.svh"

module int11_aggregator (
   input wire logic clk_sys,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // peripheral events
   input wire int11_aggr_pkg::src_events_s src_events,
   // toward the core interrupt logic and the system
   output logic core_int11_req,
   output logic irq
);
   import int11_aggr_pkg::*;

   // ==========================================================================
   // declarations
   // bus slave state
   bus_state_e bus_state_r;
   bus_state_e bus_state_nxt;
   logic [31:0] addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   // software registers
   logic [7:0] input_type_r;
   logic [7:0] output_type_r;
   logic [6:0] source_enables_r;
   logic [7:0] periph_gate_ctrl_a_r;
   logic [7:0] periph_gate_ctrl_b_r;
   logic [6:0] irq_status_r;
   logic [6:0] irq_mask_r;
   // output stages
   logic core_int11_req_r;
   logic irq_r;
   // bus decode and per-source vectors
   logic addr_phase;
   logic wr_en;
   logic rd_capture;
   logic [6:0] src_vec;
   logic [6:0] src_qual;
   logic [6:0] flags;
   logic [6:0] pendings;
   logic [6:0] flag_sets;
   logic [7:0] wdata8;
   logic wr_flags;
   logic wr_pend;
   logic [31:0] read_mux;

   // ==========================================================================
   // source qualification
   // packed struct puts the overflow in bit0 and the comparator in bit6
   assign src_vec = src_events;

   // serial sources are silent while the serial interface is switched off
   // a serial event that arrives while the interface is off is dropped, not held
   always_comb begin
      src_qual = src_vec;
      if (!periph_gate_ctrl_a_r[`GATE_A_SERIAL_EN_BIT]) begin
         src_qual[`SRC_SERIAL_ILLEGAL] = 1'b0;
         src_qual[`SRC_SERIAL_TX] = 1'b0;
      end
   end

   // ==========================================================================
   // bus front end
   // a new transfer is taken only while this slave shows ready
   // hsize is not checked; every register is a byte in the low lane of a word
   assign addr_phase = hsel & htrans[1] & hready;
   assign wr_en = (bus_state_r == BUS_WRITE);
   assign rd_capture = (bus_state_r == BUS_READ_WAIT);
   assign wdata8 = hwdata[7:0];
   assign wr_flags = wr_en & (addr_r == `ADDR_REQUEST_FLAGS);
   assign wr_pend = wr_en & (addr_r == `ADDR_PENDING_FLAGS);

   // phase sequencing; reads take one wait state so that a write in the
   // preceding data phase is already visible in the read data
   always_comb begin
      bus_state_nxt = bus_state_r;
      case (bus_state_r)
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (addr_phase && hwrite) begin
               bus_state_nxt = BUS_WRITE;
            end else if (addr_phase) begin
               bus_state_nxt = BUS_READ_WAIT;
            end else begin
               bus_state_nxt = BUS_IDLE;
            end
         end
         BUS_READ_WAIT: begin
            bus_state_nxt = BUS_READ_DONE;
         end
         default: begin
            bus_state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_state_r <= BUS_IDLE;
      end else begin
         bus_state_r <= bus_state_nxt;
      end
   end

   // address held for the data phase
   // only taken while ready is high, so a stalled read keeps its own address
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         addr_r <= 32'h0000_0000;
      end else if (addr_phase && bus_state_r != BUS_READ_WAIT) begin
         addr_r <= {haddr[31:2], 2'b00};
      end
   end

   // ready drops for exactly the read wait cycle
   // registered from the next state so hreadyout comes straight from a flip-flop
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= (bus_state_nxt != BUS_READ_WAIT);
      end
   end

   // every answer is OKAY, unmapped addresses included
   // no error path is needed since every mapped register accepts a plain word
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hresp_r <= 1'b0;
      end else begin
         hresp_r <= 1'b0;
      end
   end

   // ==========================================================================
   // per-source flag cells
   // one cell per source; a level held high on an event line counts as a
   // fresh event every cycle, so sources must pulse
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SOURCES; gi = gi + 1) begin : g_src
         src_flag_cell u_cell (
            .clk_sys(clk_sys),
            .reset(reset),
            .hw_event(src_qual[gi]),
            .enabled(source_enables_r[gi]),
            .flag_wr(wr_flags),
            .flag_wr_data(wdata8[gi]),
            .pend_wr(wr_pend),
            .pend_wr_data(wdata8[gi]),
            .flag(flags[gi]),
            .pending(pendings[gi]),
            .flag_set(flag_sets[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // software-owned registers
   // enables start at zero so nothing fires before software arms it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         source_enables_r <= `RST_ZERO7;
      end else if (wr_en && addr_r == `ADDR_SOURCE_ENABLES) begin
         source_enables_r <= wdata8[6:0];
      end
   end

   // type registers only store; the logic supports their reset values alone
   // the edge-select behaviour is fixed, so other values would not change how
   // events are taken; software is expected to leave these at reset
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         input_type_r <= `RST_INPUT_TYPE;
         output_type_r <= `RST_OUTPUT_TYPE;
      end else begin
         if (wr_en && addr_r == `ADDR_INPUT_TYPE) begin
            input_type_r <= {1'b0, wdata8[6:0]};
         end
         if (wr_en && addr_r == `ADDR_OUTPUT_TYPE) begin
            output_type_r <= wdata8;
         end
      end
   end

   // peripheral gate registers; only the serial enable and gate bits act here
   // the other gate bits belong to peripherals outside this block and are kept
   // only so software reads back what it wrote
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         periph_gate_ctrl_a_r <= `RST_ZERO8;
         periph_gate_ctrl_b_r <= `RST_ZERO8;
      end else begin
         if (wr_en && addr_r == `ADDR_PERIPH_GATE_A) begin
            periph_gate_ctrl_a_r <= wdata8;
         end
         if (wr_en && addr_r == `ADDR_PERIPH_GATE_B) begin
            periph_gate_ctrl_b_r <= wdata8;
         end
      end
   end

   // event mask, same layout as the flags
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_mask_r <= `RST_ZERO7;
      end else if (wr_en && addr_r == `ADDR_IRQ_MASK) begin
         irq_mask_r <= wdata8[6:0];
      end
   end

   // ==========================================================================
   // sticky event status, cleared by reading it; a new set beats the clear
   // the clear uses the captured address of the read wait cycle, so a read
   // that stalls never clears the status twice
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_status_r <= `RST_ZERO7;
      end else if (rd_capture && addr_r == `ADDR_IRQ_STATUS) begin
         irq_status_r <= flag_sets;
      end else begin
         irq_status_r <= irq_status_r | flag_sets;
      end
   end

   // ==========================================================================
   // read path
   // bit7 reads zero except in output type and the two gate registers; all upper bits read zero
   // the mux runs off the held address, which keeps hrdata free of the
   // next address phase that may overlap the data phase
   always_comb begin
      read_mux = 32'h0000_0000;
      case (addr_r)
         `ADDR_REQUEST_FLAGS: read_mux = {25'h0, flags};
         `ADDR_INPUT_TYPE: read_mux = {24'h0, input_type_r};
         `ADDR_OUTPUT_TYPE: read_mux = {24'h0, output_type_r};
         `ADDR_SOURCE_ENABLES: read_mux = {25'h0, source_enables_r};
         `ADDR_PENDING_FLAGS: read_mux = {25'h0, pendings};
         `ADDR_IRQ_STATUS: read_mux = {25'h0, irq_status_r};
         `ADDR_IRQ_MASK: read_mux = {25'h0, irq_mask_r};
         `ADDR_PERIPH_GATE_A: read_mux = {24'h0, periph_gate_ctrl_a_r};
         `ADDR_PERIPH_GATE_B: read_mux = {24'h0, periph_gate_ctrl_b_r};
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // read data held from the wait cycle until the next read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_capture) begin
         hrdata_r <= read_mux;
      end
   end

   // ==========================================================================
   // outputs
   // pending bits deliberately play no part in the request
   // the request lags the flag set by one edge; the core samples a level, so
   // the extra cycle costs latency only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         core_int11_req_r <= 1'b0;
      end else begin
         core_int11_req_r <= periph_gate_ctrl_b_r[`GATE_B_INT11_GATE_BIT]
            & (|(flags & source_enables_r));
      end
   end

   // system interrupt, level while any unmasked status bit stands
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

   // every top-level output is a flip-flop
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign core_int11_req = core_int11_req_r;
   assign irq = irq_r;

endmodule

`default_nettype wire

// ---- verif/int11_aggr_checker.sv ----
// port-level assertions for the interrupt-11 aggregator.
// assumes aligned single-word bus transfers; mirrors gate, enable and mask writes.
`timescale 1ns/1ps
`default_nettype none
`include "int11_aggr_consts.svh"
module int11_aggr_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire int11_aggr_pkg::src_events_s src_events,
   input wire logic core_int11_req,
   input wire logic irq
);
   import int11_aggr_pkg::*;
   logic ap;
   logic wr_pend_r;
   logic [31:0] addr_r;
   logic gate_r;
   logic [6:0] en_r;
   logic [6:0] mask_r;
   logic mapped;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ====================
   // shadow of the writes that steer the outputs
   assign ap = hsel && htrans[1] && hready;
   assign mapped = addr_r inside {`ADDR_REQUEST_FLAGS, `ADDR_INPUT_TYPE, `ADDR_OUTPUT_TYPE, `ADDR_SOURCE_ENABLES,
      `ADDR_PENDING_FLAGS, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_PERIPH_GATE_A, `ADDR_PERIPH_GATE_B};
   // data phase follows its address phase with no wait, so one stage is enough
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         addr_r <= 32'h0;
         gate_r <= 1'b0;
         en_r <= 7'h00;
         mask_r <= 7'h00;
      end else begin
         wr_pend_r <= ap && hwrite;
         if (ap) addr_r <= haddr;
         if (wr_pend_r && addr_r == `ADDR_PERIPH_GATE_B) gate_r <= hwdata[`GATE_B_INT11_GATE_BIT];
         if (wr_pend_r && addr_r == `ADDR_SOURCE_ENABLES) en_r <= hwdata[6:0];
         if (wr_pend_r && addr_r == `ADDR_IRQ_MASK) mask_r <= hwdata[6:0];
      end
   end
   // ====================
   // assertions
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_wait_a: assert property (ap && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (ap && hwrite |=> hreadyout)
      else $error("write stalled");
   wait_cause_a: assert property (!hreadyout |-> $past(ap && !hwrite))
      else $error("wait state without read");
   rdata_upper_a: assert property (hreadyout && !$past(hreadyout) |-> hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   unmapped_zero_a: assert property (hreadyout && !$past(hreadyout) && !mapped |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   gate_block_a: assert property (core_int11_req |-> $past(gate_r))
      else $error("request with gate off");
   enable_block_a: assert property (core_int11_req |-> $past(en_r) != 7'h00)
      else $error("request with no source enabled");
   event_req_a: assert property ((|(src_events & en_r & 7'h4f)) && gate_r |=> ##1 core_int11_req)
      else $error("enabled event gave no request");
   irq_mask_a: assert property (irq |-> $past(mask_r) != 7'h00)
      else $error("irq with all masked");
endmodule
bind int11_aggregator int11_aggr_checker int11_aggr_checker_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_events(src_events),
   .core_int11_req(core_int11_req), .irq(irq));
`default_nettype wire

// ---- verif/event_src_model.sv ----
// peripheral event sources seen by the aggregator.
// assumes the bench requests events with a one-cycle fire strobe on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module event_src_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic fire,
   input wire logic [6:0] fire_bits,
   output int11_aggr_pkg::src_events_s src_events
);
   import int11_aggr_pkg::*;
   // ====================
   // event pulses
   // one clean pulse per request; a held level would count once per cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         src_events <= '0;
      end else begin
         src_events <= src_events_s'(fire ? fire_bits : 7'h00);
      end
   end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the interrupt-11 aggregator.
// assumes the design's hready is its own hreadyout, one slave on the bus.
`timescale 1ns/1ps
`default_nettype none
`include "int11_aggr_consts.svh"
module tb_top;
   import int11_aggr_pkg::*;
   logic clk_sys;
   logic reset;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic fire;
   logic [6:0] fire_bits;
   src_events_s src_events;
   logic core_int11_req;
   logic irq;
   int error_cnt = 0;
   int num_checks = 0;
   int11_aggregator int11_aggregator_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .src_events(src_events), .core_int11_req(core_int11_req), .irq(irq));
   event_src_model event_src_model_inst (.clk_sys(clk_sys), .reset(reset), .fire(fire), .fire_bits(fire_bits),
      .src_events(src_events));
   // ====================
   // helpers
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // waits as long as the slave stalls; only the watchdog ends a hung wait
   task automatic wait_rdy();
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
   endtask
   task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic expect_reg(input string name, input logic [31:0] a, input logic [7:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 8'h00, q);
      check(name, q, {24'h0, e});
   endtask
   task automatic pulse(input logic [6:0] b);
      @(posedge clk_sys);
      fire <= 1'b1;
      fire_bits <= b;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ====================
   // scenarios
   task automatic s_reset();
      logic [31:0] a [10];
      logic [7:0] e [10];
      a = '{`ADDR_REQUEST_FLAGS, `ADDR_INPUT_TYPE, `ADDR_OUTPUT_TYPE, `ADDR_SOURCE_ENABLES, `ADDR_PENDING_FLAGS,
         `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_PERIPH_GATE_A, `ADDR_PERIPH_GATE_B, 32'h0000_1000};
      e = '{8'h00, 8'h7f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 10; i++) expect_reg("reset value", a[i], e[i]);
      check("req after reset", {31'h0, core_int11_req}, 32'h0);
   endtask
   task automatic s_gating();
      pulse(7'h7f);
      expect_reg("flags enables off", `ADDR_REQUEST_FLAGS, 8'h00);
      wr(`ADDR_SOURCE_ENABLES, 8'h7f);
      pulse(7'h7f);
      expect_reg("flags serial off", `ADDR_REQUEST_FLAGS, 8'h4f);
      check("req gate off", {31'h0, core_int11_req}, 32'h0);
      wr(`ADDR_PERIPH_GATE_B, 8'h08);
      repeat (2) @(posedge clk_sys);
      check("req gate on", {31'h0, core_int11_req}, 32'h1);
      wr(`ADDR_REQUEST_FLAGS, 8'h00);
      expect_reg("flags cleared", `ADDR_REQUEST_FLAGS, 8'h00);
      check("req cleared", {31'h0, core_int11_req}, 32'h0);
      wr(`ADDR_PERIPH_GATE_A, 8'h40);
      pulse(7'h30);
      expect_reg("flags serial on", `ADDR_REQUEST_FLAGS, 8'h30);
      wr(`ADDR_SOURCE_ENABLES, 8'h0f);
      expect_reg("flags kept", `ADDR_REQUEST_FLAGS, 8'h30);
      check("req disabled", {31'h0, core_int11_req}, 32'h0);
      wr(`ADDR_REQUEST_FLAGS, 8'h00);
   endtask
   task automatic s_sw_set();
      wr(`ADDR_REQUEST_FLAGS, 8'h7f);
      expect_reg("sw set", `ADDR_REQUEST_FLAGS, 8'h0f);
      check("req sw set", {31'h0, core_int11_req}, 32'h1);
      wr(`ADDR_REQUEST_FLAGS, 8'h00);
   endtask
   task automatic s_pending();
      wr(`ADDR_SOURCE_ENABLES, 8'h01);
      pulse(7'h01);
      expect_reg("pending one event", `ADDR_PENDING_FLAGS, 8'h00);
      pulse(7'h01);
      expect_reg("pending set", `ADDR_PENDING_FLAGS, 8'h01);
      // event sampled at the write's data edge: the set must beat the clear
      fork
         wr(`ADDR_REQUEST_FLAGS, 8'h00);
         begin
            @(posedge clk_sys);
            fire <= 1'b1;
            fire_bits <= 7'h01;
            @(posedge clk_sys);
            fire <= 1'b0;
         end
      join
      expect_reg("set beats clear", `ADDR_REQUEST_FLAGS, 8'h01);
      wr(`ADDR_REQUEST_FLAGS, 8'h00);
      repeat (2) @(posedge clk_sys);
      check("req pending only", {31'h0, core_int11_req}, 32'h0);
      expect_reg("pending held", `ADDR_PENDING_FLAGS, 8'h01);
      wr(`ADDR_PENDING_FLAGS, 8'h00);
      expect_reg("pending cleared", `ADDR_PENDING_FLAGS, 8'h00);
   endtask
   task automatic s_irq();
      expect_reg("status prior", `ADDR_IRQ_STATUS, 8'h7f);
      wr(`ADDR_IRQ_MASK, 8'h01);
      pulse(7'h01);
      check("irq raised", {31'h0, irq}, 32'h1);
      expect_reg("status read", `ADDR_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clk_sys);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr(`ADDR_REQUEST_FLAGS, 8'h00);
      wr(`ADDR_IRQ_MASK, 8'h02);
      pulse(7'h01);
      check("irq masked", {31'h0, irq}, 32'h0);
      expect_reg("status masked", `ADDR_IRQ_STATUS, 8'h01);
   endtask
   // ====================
   // clock, reset, sequence and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // input-type and output-type registers are never written, so they keep their defaults
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fire = 1'b0;
      fire_bits = 7'h00;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      s_reset();
      s_gating();
      s_sw_set();
      s_pending();
      s_irq();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
